// [hdl/drive_status_pkg.sv]
// constants shared by the drive status detectors
package drive_status_pkg;

  // clock and millisecond tick
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS         = 1000000;
  localparam int TICK_CYCLES   = MS_NS / CLK_PERIOD_NS;

  // timer widths and durations in milliseconds
  localparam int          TMR_W          = 16;
  localparam int          MIN_ON_MS      = 100;
  localparam logic [15:0] MIN_ON_LIMIT   = 16'(MIN_ON_MS);
  localparam int          LOSS_WINDOW_MS = 400;

  // percentages and scale factors
  localparam logic [19:0] PCT_FULL       = 20'h00064;
  localparam logic [19:0] CUR_OFF_PCT    = 20'h0005A;
  localparam logic [15:0] TORQUE_HYST    = 16'h0005;
  localparam logic [19:0] BLANK_PCT      = 20'h00014;
  localparam logic [19:0] LOSS_DROP_PCT  = 20'h0000A;
  localparam logic [19:0] RECOVER_LO_PCT = 20'h00014;
  localparam logic [15:0] RATIO_OFF      = 16'h03E7;
  localparam logic [15:0] RATIO_FULL     = 16'h0064;
  localparam logic [31:0] SPEED_NUM      = 32'h0000_0078;
  localparam logic [31:0] FREQ_SCALE     = 32'h0000_0064;
  localparam logic [31:0] WH_PER_KWH     = 32'h0000_03E8;
  localparam logic [47:0] COEFF_SCALE    = 48'h0000_0000_03E8;

  // values after reset
  localparam logic [15:0] COEFF_RST = 16'h03E8;

  // output terminal selector codes
  localparam logic [7:0] SEL_OVERLOAD   = 8'h07;
  localparam logic [7:0] SEL_CMD_LOSS   = 8'h21;
  localparam logic [7:0] SEL_CUR_DET    = 8'h25;
  localparam logic [7:0] SEL_LOW_TORQUE = 8'h2D;

endpackage

// [hdl/ms_timer.sv]
// millisecond timer: counts ticks while its condition holds
`timescale 1ns/1ps
`default_nettype none
module ms_timer
  import drive_status_pkg::*;
(
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             clk_en_i,
  input  wire logic             tick_i,
  input  wire logic             run_i,
  input  wire logic [TMR_W-1:0] limit_i,
  output logic                  done_o
);

  typedef struct packed {
    logic [TMR_W-1:0] cnt;
  } tmr_t;

  tmr_t st;
  tmr_t next_st;

  // restart when the condition drops, saturate at the top
  always_comb begin
    next_st = st;
    if (!run_i) begin
      next_st.cnt = '0;
    end else if (tick_i && st.cnt != '1) begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else if (clk_en_i) begin
      st <= next_st;
    end
  end

  // "longer than" the limit: strictly beyond it
  assign done_o = run_i && (st.cnt > limit_i);

endmodule
`default_nettype wire

// [hdl/drive_status_detectors.sv]
// status detectors of a motor inverter: current, torque, command loss, energy, speed
//
// Notes on behaviour
// R1 - overload early warning on while output current exceeds warning level
// R2 - current-detected flag sets after current stays above level beyond detect timer
// R3 - current-detected flag clears when current falls below 90% of level
// R4 - current-detected flag stays on at least 100 ms each time
// R5 - terminal code 7 overload, 37 current detected, 45 low torque
// R6 - energy display is accumulated kWh times display coefficient
// R7 - writing coefficient zero clears accumulator and displayed energy
// R8 - no accumulation while coefficient is zero; resumes on nonzero value
// R9 - command loss when analog command drops below 10% within 400 ms
// R10 - during loss run at loss ratio times previously sampled reference
// R11 - loss ends once command rises above the loss ratio level
// R12 - ratio 999 still flags loss but reference keeps following command
// R13 - ratio 0 or 999 recovers above 0.2 times sampled level f1
// R14 - ratio 100% or more recovers above full sampled level f1
// R15 - loss detection uses unfiltered analog input, filter constants ignored
// R16 - low-torque flag sets when torque below level longer than timer
// R17 - low-torque flag clears when torque exceeds level plus 5%
// R18 - low-torque flag stays on at least 100 ms each time
// R19 - torque level scaled so 100% equals rated motor torque
// R20 - below 20% of base frequency detection suspended, flag held
// R21 - low-torque flag forced off while inverter is stopped
// R22 - motor speed equals 120 over pole count times frequency
// R23 - command-loss flag high during loss, low once analog operation resumes
// R24 - timers count a millisecond tick, restart when condition goes false
`timescale 1ns/1ps
`default_nettype none
module drive_status_detectors
  import drive_status_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
)
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        clk_en_i,
  // measurement front end
  input  wire logic [15:0] out_current_i,
  input  wire logic [15:0] torque_pct_i,
  input  wire logic [15:0] out_freq_i,
  input  wire logic [15:0] analog_cmd_i,
  input  wire logic        running_i,
  input  wire logic        energy_valid_i,
  input  wire logic [15:0] energy_wh_i,
  // settings
  input  wire logic [15:0] current_warn_level,
  input  wire logic [15:0] current_detect_timer,
  input  wire logic [15:0] low_torque_level,
  input  wire logic [15:0] low_torque_timer,
  input  wire logic [15:0] base_freq_setting,
  input  wire logic [15:0] cmd_loss_ratio,
  input  wire logic [7:0]  pole_count,
  input  wire logic        coeff_wr_i,
  input  wire logic [15:0] energy_display_coeff,
  input  wire logic [7:0]  term_sel_i,
  // status
  output logic             overload_early_warn_o,
  output logic             current_detected_flag_o,
  output logic             low_torque_flag_o,
  output logic             cmd_loss_flag_o,
  output logic [15:0]      ref_freq_o,
  output logic [31:0]      energy_kwh_o,
  output logic [31:0]      energy_disp_o,
  output logic [15:0]      motor_speed_o,
  output logic             term_out_o
);

  localparam int TICK_W = $clog2(TICK_CYC + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
  localparam logic [8:0] WIN_LAST = 9'(LOSS_WINDOW_MS - 1);

  typedef enum logic [0:0] {
    LOSS_IDLE = 1'b0,
    LOSS_HELD = 1'b1
  } loss_state_t;

  typedef struct packed {
    logic [TICK_W-1:0] tick_cnt;
    logic              tick;
    logic              ol;
    logic              id;
    logic              utl;
    loss_state_t       loss;
    logic [8:0]        win_ms;
    logic [15:0]       f1;
    logic [15:0]       ref_freq;
    logic [15:0]       coeff;
    logic [31:0]       acc_wh;
    logic [31:0]       kwh;
    logic [31:0]       disp;
    logic [15:0]       speed;
    logic              term;
  } state_t;

  state_t st;
  state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // detection conditions

  logic        cur_above;
  logic        cur_below_off;
  logic        torque_below;
  logic        torque_above_hyst;
  logic        low_freq_blank;
  logic        cmd_dropped;
  logic        cmd_recovered;
  logic [15:0] loss_ref;
  logic [15:0] recover_lvl;
  logic [31:0] loss_prod;
  logic [31:0] rec_prod;
  logic        id_timer_done;
  logic        id_hold_done;
  logic        utl_timer_done;
  logic        utl_hold_done;
  logic [47:0] disp_prod;
  logic [31:0] speed_prod;
  logic [31:0] speed_div;

  // current comparisons, off level widened to avoid overflow
  assign cur_above     = out_current_i > current_warn_level;                         // [R1]
  assign cur_below_off = ({8'h00, out_current_i} * PCT_FULL)
                         < ({8'h00, current_warn_level} * CUR_OFF_PCT);             // [R3]

  // torque and level share one scale: 100 is rated torque
  assign torque_below      = torque_pct_i < low_torque_level;                       // [R19]
  assign torque_above_hyst = {1'b0, torque_pct_i}
                             > ({1'b0, low_torque_level} + {1'b0, TORQUE_HYST});    // [R17]

  // torque estimate is poor at low speed, so detection is blanked there
  assign low_freq_blank = ({8'h00, out_freq_i} * PCT_FULL)
                          < ({8'h00, base_freq_setting} * BLANK_PCT);               // [R20]

  // raw analog input, never the filtered copy
  assign cmd_dropped = ({8'h00, analog_cmd_i} * PCT_FULL)
                       < ({8'h00, st.f1} * LOSS_DROP_PCT);                          // [R9] [R15]

  // substitute reference during loss
  assign loss_prod = {16'h0000, st.f1} * {16'h0000, cmd_loss_ratio};
  assign loss_ref  = 16'(loss_prod / {12'h000, PCT_FULL});                          // [R10]

  // recovery level depends on how the ratio is set
  assign rec_prod = {16'h0000, st.f1} * {12'h000, RECOVER_LO_PCT};
  always_comb begin
    if (cmd_loss_ratio == 16'h0000 || cmd_loss_ratio == RATIO_OFF) begin
      recover_lvl = 16'(rec_prod / {12'h000, PCT_FULL});                            // [R13]
    end else if (cmd_loss_ratio >= RATIO_FULL) begin
      recover_lvl = st.f1;                                                          // [R14]
    end else begin
      recover_lvl = loss_ref;                                                       // [R11]
    end
  end
  assign cmd_recovered = analog_cmd_i > recover_lvl;                                // [R11]

  // display arithmetic
  assign disp_prod  = {16'h0000, st.kwh} * {32'h0000_0000, st.coeff};
  assign speed_prod = SPEED_NUM * {16'h0000, out_freq_i};
  assign speed_div  = (pole_count == 8'h00) ? 32'h0000_0000
                      : speed_prod / (FREQ_SCALE * {24'h00_0000, pole_count});      // [R22]

  ////////////////////////////////////////////////////////////////////////////
  // timers on the shared millisecond tick

  // current must stay above level beyond the detect timer
  ms_timer u_id_timer (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .clk_en_i  (clk_en_i),
    .tick_i    (st.tick),
    .run_i     (cur_above),
    .limit_i   (current_detect_timer),
    .done_o    (id_timer_done)
  );                                                                                // [R2] [R24]

  // minimum on time of the current-detected flag
  ms_timer u_id_hold (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .clk_en_i  (clk_en_i),
    .tick_i    (st.tick),
    .run_i     (st.id),
    .limit_i   (MIN_ON_LIMIT),
    .done_o    (id_hold_done)
  );                                                                                // [R4] [R24]

  // torque must stay low beyond the low-torque timer, only while measurable
  ms_timer u_utl_timer (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .clk_en_i  (clk_en_i),
    .tick_i    (st.tick),
    .run_i     (torque_below && running_i && !low_freq_blank),
    .limit_i   (low_torque_timer),
    .done_o    (utl_timer_done)
  );                                                                                // [R16] [R24]

  // minimum on time of the low-torque flag
  ms_timer u_utl_hold (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .clk_en_i  (clk_en_i),
    .tick_i    (st.tick),
    .run_i     (st.utl),
    .limit_i   (MIN_ON_LIMIT),
    .done_o    (utl_hold_done)
  );                                                                                // [R18] [R24]

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st = st;

    // millisecond tick, one cycle wide
    next_st.tick = 1'b0;
    if (st.tick_cnt == TICK_LAST) begin
      next_st.tick_cnt = '0;
      next_st.tick     = 1'b1;                                                      // [R24]
    end else begin
      next_st.tick_cnt = st.tick_cnt + 1'b1;
    end

    // overload early warning follows the level directly
    next_st.ol = cur_above;                                                         // [R1]

    // current detected: set wins over a pending clear
    if (id_timer_done) begin
      next_st.id = 1'b1;                                                            // [R2]
    end else if (st.id && cur_below_off && id_hold_done) begin
      next_st.id = 1'b0;                                                            // [R3] [R4]
    end

    // low torque: stop forces off, blanking holds the last decision
    if (!running_i) begin
      next_st.utl = 1'b0;                                                           // [R21]
    end else if (low_freq_blank) begin
      next_st.utl = st.utl;                                                         // [R20]
    end else if (utl_timer_done) begin
      next_st.utl = 1'b1;                                                           // [R16]
    end else if (st.utl && torque_above_hyst && utl_hold_done) begin
      next_st.utl = 1'b0;                                                           // [R17] [R18]
    end

    // command loss: compare against f1 at each window boundary
    if (st.tick) begin
      next_st.win_ms = (st.win_ms == WIN_LAST) ? 9'h000 : st.win_ms + 9'h001;
    end
    unique case (st.loss)
      LOSS_IDLE: begin
        next_st.ref_freq = analog_cmd_i;
        if (st.tick && st.win_ms == WIN_LAST) begin
          if (cmd_dropped) begin
            next_st.loss = LOSS_HELD;                                               // [R9] [R23]
            if (cmd_loss_ratio != RATIO_OFF) begin
              next_st.ref_freq = loss_ref;                                          // [R10]
            end
          end else begin
            next_st.f1 = analog_cmd_i;                                              // [R15]
          end
        end
      end
      LOSS_HELD: begin
        // f1 is frozen while in loss so the substitute stays put
        if (cmd_loss_ratio == RATIO_OFF) begin
          next_st.ref_freq = analog_cmd_i;                                          // [R12]
        end else begin
          next_st.ref_freq = loss_ref;                                              // [R10]
        end
        if (cmd_recovered) begin
          next_st.loss     = LOSS_IDLE;                                             // [R11] [R23]
          next_st.ref_freq = analog_cmd_i;
          next_st.f1       = analog_cmd_i;
          next_st.win_ms   = 9'h000;
        end
      end
    endcase

    // energy accumulator, gated by a nonzero coefficient
    if (coeff_wr_i) begin
      next_st.coeff = energy_display_coeff;
    end
    if (coeff_wr_i && energy_display_coeff == 16'h0000) begin
      next_st.acc_wh = 32'h0000_0000;                                               // [R7]
      next_st.kwh    = 32'h0000_0000;
      next_st.disp   = 32'h0000_0000;                                               // [R7]
    end else begin
      if (energy_valid_i && st.coeff != 16'h0000) begin
        next_st.acc_wh = st.acc_wh + {16'h0000, energy_wh_i};                       // [R8]
      end
      next_st.kwh  = st.acc_wh / WH_PER_KWH;
      // coefficient is held in thousandths
      next_st.disp = 32'(disp_prod / COEFF_SCALE);                                  // [R6]
    end

    // speed display
    next_st.speed = speed_div[15:0];                                                // [R22]

    // output terminal selector
    unique case (term_sel_i)
      SEL_OVERLOAD:   next_st.term = next_st.ol;                                    // [R5]
      SEL_CUR_DET:    next_st.term = next_st.id;                                    // [R5]
      SEL_LOW_TORQUE: next_st.term = next_st.utl;                                   // [R5]
      SEL_CMD_LOSS:   next_st.term = (next_st.loss == LOSS_HELD);
      default:        next_st.term = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  // clock enable low freezes everything, including the tick
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st       <= '0;
      st.loss  <= LOSS_IDLE;
      st.coeff <= COEFF_RST;
    end else if (clk_en_i) begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register

  assign overload_early_warn_o   = st.ol;
  assign current_detected_flag_o = st.id;
  assign low_torque_flag_o       = st.utl;
  assign cmd_loss_flag_o         = (st.loss == LOSS_HELD);                          // [R23]
  assign ref_freq_o              = st.ref_freq;
  assign energy_kwh_o            = st.kwh;
  assign energy_disp_o           = st.disp;
  assign motor_speed_o           = st.speed;
  assign term_out_o              = st.term;

endmodule
`default_nettype wire

// [dv/drive_status_detectors_sva.sv]
// concurrent checks on the ports of the drive status detectors
`timescale 1ns/1ps
`default_nettype none
module drive_status_sva
  import drive_status_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
)
(
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic        clk_en_i,
  input wire logic [15:0] out_current_i,
  input wire logic [15:0] out_freq_i,
  input wire logic [15:0] analog_cmd_i,
  input wire logic        running_i,
  input wire logic [15:0] current_warn_level,
  input wire logic [15:0] current_detect_timer,
  input wire logic [15:0] base_freq_setting,
  input wire logic [15:0] cmd_loss_ratio,
  input wire logic [7:0]  pole_count,
  input wire logic        coeff_wr_i,
  input wire logic [15:0] energy_display_coeff,
  input wire logic [7:0]  term_sel_i,
  input wire logic        overload_early_warn_o,
  input wire logic        current_detected_flag_o,
  input wire logic        low_torque_flag_o,
  input wire logic        cmd_loss_flag_o,
  input wire logic [15:0] ref_freq_o,
  input wire logic [31:0] energy_kwh_o,
  input wire logic [31:0] energy_disp_o,
  input wire logic [15:0] motor_speed_o,
  input wire logic        term_out_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // cycle counts keep the long ms figures out of the properties
  logic [31:0] id_on;
  logic [31:0] above;
  always_ff @(posedge sys_clk_i) begin
    id_on <= (rst_n_i && current_detected_flag_o) ? id_on + 32'h1 : 32'h0;
    above <= (rst_n_i && out_current_i > current_warn_level) ? above + 32'(clk_en_i) : 32'h0;
  end

  ol_follow_a: assert property (
    clk_en_i |=> overload_early_warn_o == $past(out_current_i > current_warn_level))
    else $error("overload warning wrong");
  id_set_a: assert property (
    $rose(current_detected_flag_o) |-> above >= 32'(current_detect_timer) * TICK_CYC)
    else $error("current flag set early");
  id_clear_a: assert property (
    $fell(current_detected_flag_o) && $past(rst_n_i) |->
      $past(32'(out_current_i) * PCT_FULL < 32'(current_warn_level) * CUR_OFF_PCT))
    else $error("current flag cleared high");
  id_min_a: assert property (
    $fell(current_detected_flag_o) && $past(rst_n_i) |-> id_on >= MIN_ON_MS * TICK_CYC)
    else $error("current flag too short");
  utl_stop_a: assert property (
    clk_en_i && !running_i |=> !low_torque_flag_o)
    else $error("low torque flag on while stopped");
  utl_hold_a: assert property (
    clk_en_i && running_i && 32'(out_freq_i) * PCT_FULL < 32'(base_freq_setting) * BLANK_PCT
      |=> $stable(low_torque_flag_o))
    else $error("blanked flag moved");
  term_route_a: assert property (
    $past(clk_en_i) && $past(rst_n_i) |-> term_out_o ==
      ($past(term_sel_i) == SEL_OVERLOAD ? overload_early_warn_o :
       $past(term_sel_i) == SEL_CUR_DET ? current_detected_flag_o :
       $past(term_sel_i) == SEL_LOW_TORQUE ? low_torque_flag_o :
       $past(term_sel_i) == SEL_CMD_LOSS && cmd_loss_flag_o))
    else $error("terminal output wrong");
  ref_follow_a: assert property (
    $past(clk_en_i) && $past(rst_n_i) && (!cmd_loss_flag_o || $past(cmd_loss_ratio) == RATIO_OFF)
      |-> ref_freq_o == $past(analog_cmd_i))
    else $error("reference not following");
  speed_conv_a: assert property (
    $past(clk_en_i) && $past(rst_n_i) && $past(pole_count) != 8'h00 |-> motor_speed_o ==
      16'(SPEED_NUM * $past(out_freq_i) / (FREQ_SCALE * $past(pole_count))))
    else $error("motor speed conversion wrong");
  energy_clr_a: assert property (
    clk_en_i && coeff_wr_i && energy_display_coeff == 16'h0000 |->
      ##[1:2] (energy_kwh_o == 32'h0 && energy_disp_o == 32'h0))
    else $error("energy not cleared");
endmodule

bind drive_status_detectors drive_status_sva #(.TICK_CYC(TICK_CYC)) sva (.*);
`default_nettype wire

// [dv/meas_front_end.sv]
// measurement front end model: measured values and energy pulses
`timescale 1ns/1ps
`default_nettype none
module meas_front_end (
  input  wire logic        sys_clk_i,
  output logic [15:0] out_current_o,
  output logic [15:0] torque_pct_o,
  output logic [15:0] out_freq_o,
  output logic [15:0] analog_cmd_o,
  output logic        running_o,
  output logic        energy_valid_o,
  output logic [15:0] energy_wh_o
);
  // quiet, stopped front end until the bench asks for more
  initial begin
    {out_current_o, torque_pct_o, out_freq_o, analog_cmd_o} = 64'h0;
    {running_o, energy_valid_o, energy_wh_o} = 18'h0;
  end

  // new measurements land together on one edge
  task automatic apply(input logic [15:0] cur, tq = 16'h0064, fr = 16'h1388,
                       an = 16'h03E8, input logic run = 1'b1);
    @(posedge sys_clk_i);
    out_current_o <= cur;
    torque_pct_o  <= tq;
    out_freq_o    <= fr;
    analog_cmd_o  <= an;
    running_o     <= run;
  endtask

  // one cycle energy increment
  task automatic pulse_energy(input logic [15:0] wh);
    @(posedge sys_clk_i);
    energy_valid_o <= 1'b1;
    energy_wh_o    <= wh;
    @(posedge sys_clk_i);
    energy_valid_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [dv/test_drive_status_detectors.sv]
// self-checking bench for the drive status detectors
`timescale 1ns/1ps
`default_nettype none
module test_drive_status_detectors;
  import drive_status_pkg::*;
  localparam int TK = 10;
  int          errors      = 0;
  int          checks_done = 0;
  logic        sys_clk_i = 1'b0, rst_n_i = 1'b0, clk_en_i = 1'b1, coeff_wr_i = 1'b0;
  logic [7:0]  pole_count = 8'h00, term_sel_i = 8'h00;
  logic [15:0] current_warn_level = 16'h0, current_detect_timer = 16'h0;
  logic [15:0] low_torque_level = 16'h0, low_torque_timer = 16'h0, base_freq_setting = 16'h0;
  logic [15:0] cmd_loss_ratio = 16'h0, energy_display_coeff = 16'h0;
  logic [15:0] out_current_i, torque_pct_i, out_freq_i, analog_cmd_i, energy_wh_i;
  logic        running_i, energy_valid_i;
  logic        overload_early_warn_o, current_detected_flag_o, low_torque_flag_o;
  logic        cmd_loss_flag_o, term_out_o;
  logic [15:0] ref_freq_o, motor_speed_o;
  logic [31:0] energy_kwh_o, energy_disp_o;

  always #2 sys_clk_i = ~sys_clk_i;

  drive_status_detectors #(.TICK_CYC(TK)) uut (.*);

  meas_front_end fe (
    .sys_clk_i, .out_current_o(out_current_i), .torque_pct_o(torque_pct_i),
    .out_freq_o(out_freq_i), .analog_cmd_o(analog_cmd_i), .running_o(running_i),
    .energy_valid_o(energy_valid_i), .energy_wh_o(energy_wh_i)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // waits end 1 ns past an edge so registered outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic ms(input int n);
    cyc(n * TK);
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic wr_coeff(input logic [15:0] v);
    @(posedge sys_clk_i);
    energy_display_coeff <= v;
    coeff_wr_i           <= 1'b1;
    @(posedge sys_clk_i);
    coeff_wr_i           <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // current above 500 with a 5 ms timer; a dip must restart the timer
  task automatic t_current();
    @(posedge sys_clk_i);
    current_warn_level   <= 16'h01F4;
    current_detect_timer <= 16'h0005;
    term_sel_i           <= SEL_OVERLOAD;
    fe.apply(16'h0258);
    ms(3);
    chk("overload", 32'h1, overload_early_warn_o);
    chk("term overload", 32'h1, term_out_o);
    fe.apply(16'h0190);
    cyc(2);
    fe.apply(16'h0258);
    ms(5);
    chk("id restarted", 32'h0, current_detected_flag_o);
    ms(3);
    chk("id set", 32'h1, current_detected_flag_o);
    @(posedge sys_clk_i);
    term_sel_i <= SEL_CUR_DET;
    fe.apply(16'h01CC);
    cyc(3);
    chk("overload off", 32'h0, overload_early_warn_o);
    chk("term id", 32'h1, term_out_o);
    ms(105);
    chk("id above release", 32'h1, current_detected_flag_o);
    fe.apply(16'h01B8);
    cyc(3);
    chk("id released", 32'h0, current_detected_flag_o);
    fe.apply(16'h0258);
    ms(8);
    fe.apply(16'h0000);
    ms(50);
    chk("id min width", 32'h1, current_detected_flag_o);
    ms(55);
    chk("id after width", 32'h0, current_detected_flag_o);
  endtask

  // torque under 30 percent for 3 ms, then hysteresis, blanking and stop
  task automatic t_torque();
    @(posedge sys_clk_i);
    low_torque_level  <= 16'h001E;
    low_torque_timer  <= 16'h0003;
    base_freq_setting <= 16'h1770;
    pole_count        <= 8'h04;
    term_sel_i        <= SEL_LOW_TORQUE;
    fe.apply(16'h0000, 16'h0014);
    ms(2);
    chk("utl early", 32'h0, low_torque_flag_o);
    ms(4);
    chk("utl set", 32'h1, low_torque_flag_o);
    chk("term utl", 32'h1, term_out_o);
    chk("speed", 32'h05DC, motor_speed_o);
    fe.apply(16'h0000, 16'h0022);
    ms(105);
    chk("utl in band", 32'h1, low_torque_flag_o);
    fe.apply(16'h0000, 16'h0032, 16'h03E8);
    ms(10);
    chk("utl blanked", 32'h1, low_torque_flag_o);
    fe.apply(16'h0000, 16'h0032);
    cyc(3);
    chk("utl clear", 32'h0, low_torque_flag_o);
    fe.apply(16'h0000, 16'h0014);
    ms(6);
    fe.apply(16'h0000, 16'h0014, 16'h1388, 16'h03E8, 1'b0);
    cyc(3);
    chk("utl stopped", 32'h0, low_torque_flag_o);
  endtask

  // f1 of 1000 then a step to 50, for ratios 50, 999, 100 and 0
  task automatic t_loss();
    logic [15:0] rat [4] = '{16'h0032, 16'h03E7, 16'h0064, 16'h0000};
    logic [15:0] sub [4] = '{16'h01F4, 16'h0032, 16'h03E8, 16'h0000};
    logic [15:0] lo  [4] = '{16'h01C2, 16'h0096, 16'h03B6, 16'h0096};
    logic [15:0] hi  [4] = '{16'h0226, 16'h00FA, 16'h041A, 16'h00FA};
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk_i);
      cmd_loss_ratio <= rat[k];
      term_sel_i     <= SEL_CMD_LOSS;
      fe.apply(16'h0000);
      ms(405);
      chk("loss idle", 32'h0, cmd_loss_flag_o);
      fe.apply(16'h0000, 16'h0064, 16'h1388, 16'h0032);
      ms(405);
      chk("loss set", 32'h1, cmd_loss_flag_o);
      chk("substitute ref", 32'(sub[k]), ref_freq_o);
      fe.apply(16'h0000, 16'h0064, 16'h1388, lo[k]);
      cyc(3);
      chk("loss held", 32'h1, cmd_loss_flag_o);
      fe.apply(16'h0000, 16'h0064, 16'h1388, hi[k]);
      cyc(3);
      chk("loss ended", 32'h0, cmd_loss_flag_o);
      chk("ref resumed", 32'(hi[k]), ref_freq_o);
    end
  endtask

  // 3000 Wh shown at two coefficients, then cleared and frozen at zero
  task automatic t_energy();
    repeat (3) fe.pulse_energy(16'h03E8);
    cyc(4);
    chk("kwh", 32'h3, energy_kwh_o);
    chk("disp", 32'h3, energy_disp_o);
    wr_coeff(16'h09C4);
    cyc(4);
    chk("disp scaled", 32'h7, energy_disp_o);
    wr_coeff(16'h0000);
    cyc(3);
    chk("kwh cleared", 32'h0, energy_kwh_o);
    chk("disp cleared", 32'h0, energy_disp_o);
    repeat (2) fe.pulse_energy(16'h03E8);
    cyc(4);
    chk("kwh frozen", 32'h0, energy_kwh_o);
    wr_coeff(16'h03E8);
    fe.pulse_energy(16'h03E8);
    cyc(4);
    chk("kwh resumed", 32'h1, energy_kwh_o);
    @(posedge sys_clk_i);
    clk_en_i <= 1'b0;
    fe.pulse_energy(16'h03E8);
    clk_en_i <= 1'b1;
    cyc(2);
    chk("kwh enable low", 32'h1, energy_kwh_o);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    cyc(2);
    t_current();
    t_torque();
    t_loss();
    t_energy();
    tally_and_finish();
  end

  // the full run needs about 36000 cycles
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
